// ---- rtl/sorc_serial_ctrl.sv ----
// Purpose: serial write path and control word decoder of an output driver
// Assumes: serial clock well below clk/4; software mode selected by strap low
// Notes: readback, status, fault and crc checking are not part of this block
// Function
// [RULE_01] sixteen-bit shift register, one word per command
// [RULE_02] words travel msb first
// [RULE_03] data sampled on serial clock falling edges
// [RULE_04] top three bits carry board address
// [RULE_05] act only when address matches strap pins
// [RULE_06] controller sends bits 11, 1, 0 as zero
// [RULE_07] bit 12 selects write or read
// [RULE_08] write fields: range, clear_level_select, output_enable_bit, clear, rsel, reset
// [RULE_09] rsel zero codes 0-2 select external-resistor currents
// [RULE_10] rsel zero voltage codes map six ranges
// [RULE_11] rsel one selects internal-resistor currents, 5/10 V
// [RULE_12] controller never writes unused range combinations
// [RULE_13] software reset restores power-on state, bit self-clears
// [RULE_14] controller enables output and range together
// [RULE_15] serial path active only with mode strap low
// [RULE_16] mismatched address leaves control fields unchanged
// [RULE_17] fields update only after full closed frame
module sorc_serial_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sync_n,
  input wire logic addr_strap_pin2,
  input wire logic addr_strap_pin1,
  input wire logic addr_strap_pin0,
  input wire logic control_mode_strap,
  output logic [15:0] output_control_word,
  output logic [3:0] range_code,
  output logic clear_level_select,
  output logic output_enable_bit,
  output logic sense_resistor_select,
  output logic sw_clear_pulse,
  output logic sw_reset_pulse,
  output logic read_request_pulse,
  output logic [3:0] output_config,
  output logic config_unused,
  output logic current_out_en,
  output logic voltage_out_en
);
  // ---------------------------------------------------------------
  // synchronised pins
  // ---------------------------------------------------------------
  sorc_link_if link ();

  sorc_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .sdin(sdin),
    .sync_n(sync_n),
    .link(link)
  );

  typedef struct packed {
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic mode_s1;
    logic mode_s2;
    logic sclk_prev;
    logic sync_prev;
    logic [sorc_pkg::WORD_W-1:0] shift;
    logic [sorc_pkg::CNT_W-1:0] count;
    logic [sorc_pkg::WORD_W-1:0] ctrl;
    logic clr_p;
    logic rst_p;
    logic rd_p;
  } sorc_state_t;

  sorc_state_t st_q;
  sorc_state_t st_d;

  // ---------------------------------------------------------------
  // range decode
  // ---------------------------------------------------------------
  function automatic sorc_pkg::sorc_cfg_t sorc_decode(input logic rsel, input logic [3:0] code);
    sorc_pkg::sorc_cfg_t cfg;
    cfg = sorc_pkg::SORC_CFG_UNUSED;
    case ({rsel, code})
      5'h00: cfg = sorc_pkg::SORC_CFG_I4_20; // [RULE_09]
      5'h01: cfg = sorc_pkg::SORC_CFG_I0_20; // [RULE_09]
      5'h02: cfg = sorc_pkg::SORC_CFG_I0_24; // [RULE_09]
      5'h05: cfg = sorc_pkg::SORC_CFG_V0_5; // [RULE_10]
      5'h06: cfg = sorc_pkg::SORC_CFG_V0_10; // [RULE_10]
      5'h09: cfg = sorc_pkg::SORC_CFG_V0_6; // [RULE_10]
      5'h0a: cfg = sorc_pkg::SORC_CFG_V0_12; // [RULE_10]
      5'h0e: cfg = sorc_pkg::SORC_CFG_V0_40; // [RULE_10]
      5'h0f: cfg = sorc_pkg::SORC_CFG_V0_44; // [RULE_10]
      5'h10: cfg = sorc_pkg::SORC_CFG_I4_20; // [RULE_11]
      5'h11: cfg = sorc_pkg::SORC_CFG_I0_20; // [RULE_11]
      5'h12: cfg = sorc_pkg::SORC_CFG_I0_24; // [RULE_11]
      5'h15: cfg = sorc_pkg::SORC_CFG_V0_5; // [RULE_11]
      5'h16: cfg = sorc_pkg::SORC_CFG_V0_10; // [RULE_11]
      default: cfg = sorc_pkg::SORC_CFG_UNUSED;
    endcase
    return cfg;
  endfunction

  function automatic logic sorc_is_current(input sorc_pkg::sorc_cfg_t cfg);
    return (cfg == sorc_pkg::SORC_CFG_I4_20) || (cfg == sorc_pkg::SORC_CFG_I0_20) ||
           (cfg == sorc_pkg::SORC_CFG_I0_24);
  endfunction

  // ---------------------------------------------------------------
  // frame capture and command decode
  // ---------------------------------------------------------------
  logic sclk_fall;
  logic frame_end;
  logic sw_mode;
  logic addr_hit;
  logic [15:0] word_in;

  assign sw_mode = !st_q.mode_s2; // [RULE_15]
  assign sclk_fall = st_q.sclk_prev && !link.sclk_s; // [RULE_03]
  assign frame_end = !st_q.sync_prev && link.sync_n_s;
  assign word_in = st_q.shift;
  assign addr_hit = (word_in[sorc_pkg::ADDR_HI:sorc_pkg::ADDR_LO] == // [RULE_04]
                     st_q.strap_s2); // [RULE_05]

  always_comb begin
    st_d = st_q;
    st_d.strap_s1 = {addr_strap_pin2, addr_strap_pin1, addr_strap_pin0};
    st_d.strap_s2 = st_q.strap_s1;
    st_d.mode_s1 = control_mode_strap;
    st_d.mode_s2 = st_q.mode_s1;
    st_d.sclk_prev = link.sclk_s;
    st_d.sync_prev = link.sync_n_s;
    st_d.clr_p = 1'b0;
    st_d.rst_p = 1'b0;
    st_d.rd_p = 1'b0;
    // a software reset command self-clears: the stored reset bit never stays set
    st_d.ctrl[sorc_pkg::SWRST_BIT] = 1'b0; // [RULE_13]
    st_d.ctrl[sorc_pkg::SWCLR_BIT] = 1'b0;
    if (!sw_mode) begin
      st_d.count = '0;
    end else if (link.sync_n_s) begin
      // frame closed: the counter rearms for the next word
      st_d.count = '0;
      // [RULE_17] a short or long frame is discarded whole
      if (frame_end && (st_q.count == sorc_pkg::BIT_COUNT_FULL) && addr_hit) begin // [RULE_16]
        if (!word_in[sorc_pkg::RW_BIT]) begin // [RULE_07]
          if (word_in[sorc_pkg::SWRST_BIT]) begin
            st_d.ctrl = sorc_pkg::CTRL_RESET; // [RULE_13]
            st_d.rst_p = 1'b1;
          end else begin
            st_d.ctrl = word_in; // [RULE_08]
            st_d.ctrl[sorc_pkg::SWCLR_BIT] = 1'b0;
            st_d.clr_p = word_in[sorc_pkg::SWCLR_BIT];
          end
        end else begin
          st_d.rd_p = 1'b1; // [RULE_07]
        end
      end
    end else if (sclk_fall) begin
      // msb lands at bit 15 after sixteen shifts
      st_d.shift = {st_q.shift[14:0], link.sdin_s}; // [RULE_01] [RULE_02]
      if (st_q.count != sorc_pkg::BIT_COUNT_FULL + 5'h01) begin
        st_d.count = st_q.count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.sclk_prev <= 1'b1;
      st_q.sync_prev <= 1'b1;
      st_q.mode_s1 <= 1'b1;
      st_q.mode_s2 <= 1'b1;
      st_q.ctrl <= sorc_pkg::CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  sorc_pkg::sorc_cfg_t cfg_now;
  assign cfg_now = sorc_decode(st_q.ctrl[sorc_pkg::RSEL_BIT],
                               st_q.ctrl[sorc_pkg::RANGE_HI:sorc_pkg::RANGE_LO]);

  assign output_control_word = st_q.ctrl;
  assign range_code = st_q.ctrl[sorc_pkg::RANGE_HI:sorc_pkg::RANGE_LO];
  assign clear_level_select = st_q.ctrl[sorc_pkg::CLEAR_LEVEL_SELECT_BIT];
  assign output_enable_bit = st_q.ctrl[sorc_pkg::OUTPUT_ENABLE_BIT_BIT];
  assign sense_resistor_select = st_q.ctrl[sorc_pkg::RSEL_BIT];
  assign sw_clear_pulse = st_q.clr_p;
  assign sw_reset_pulse = st_q.rst_p;
  assign read_request_pulse = st_q.rd_p;
  assign output_config = cfg_now;
  assign config_unused = (cfg_now == sorc_pkg::SORC_CFG_UNUSED);
  // unused codes keep both channels off rather than guess a range
  assign current_out_en = output_enable_bit && sorc_is_current(cfg_now);
  assign voltage_out_en = output_enable_bit && !config_unused && !sorc_is_current(cfg_now);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  addr_guard_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
    (frame_end && sw_mode && !addr_hit) |=> $stable(st_q.ctrl[15:5]))
    else $error("control changed on foreign address");
  frame_len_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_17]
    ($changed(st_q.ctrl[15:5])) |-> $past(frame_end) && $past(st_q.count) == 5'h10)
    else $error("control changed outside a full closed frame");
  write_only_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
    (frame_end && sw_mode && addr_hit && st_q.count == 5'h10 && word_in[12]) |=>
    $stable(st_q.ctrl) ##0 st_q.rd_p)
    else $error("read word altered control");
  load_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    (frame_end && sw_mode && addr_hit && st_q.count == 5'h10 && !word_in[12] && !word_in[2])
    |=> st_q.ctrl[15:5] == $past(word_in[15:5]) && st_q.ctrl[3] == $past(word_in[3]))
    else $error("write word not loaded");
  sw_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
    st_q.rst_p |-> st_q.ctrl == 16'h0000 && !output_enable_bit ##1 !st_q.ctrl[2])
    else $error("software reset left state behind");
  hw_mode_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
    (st_q.mode_s2 && $past(st_q.mode_s2)) |-> $stable(st_q.ctrl[15:5]))
    else $error("serial write accepted in hardware mode");
  shift_msb_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_02]
    (sw_mode && !link.sync_n_s && sclk_fall) |=> st_q.shift[0] == $past(link.sdin_s)
    && st_q.shift[15:1] == $past(st_q.shift[14:0]))
    else $error("shift order wrong");
  chan_excl_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    !(current_out_en && voltage_out_en) && (output_enable_bit || !current_out_en))
    else $error("both channels enabled");
  range_ext_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    (st_q.ctrl[3] == 1'b0 && st_q.ctrl[10:7] == 4'hf) |-> output_config == 4'h9)
    else $error("forty-four volt code misdecoded");

  // ---------------------------------------------------------------
  // pulse and frame checks
  // ---------------------------------------------------------------
  // pulses drive one-shot actions downstream, so a stretched one would act twice
  clr_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    st_q.clr_p |=> !st_q.clr_p)
    else $error("clear pulse longer than one cycle");
  rst_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
    st_q.rst_p |=> !st_q.rst_p)
    else $error("reset pulse longer than one cycle");
  rd_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
    st_q.rd_p |=> !st_q.rd_p)
    else $error("read pulse longer than one cycle");
  clr_cause_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
    st_q.clr_p |-> $past(frame_end) && $past(word_in[sorc_pkg::SWCLR_BIT])
    && !$past(word_in[sorc_pkg::RW_BIT]))
    else $error("clear pulse without a clear write");
  rd_cause_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
    st_q.rd_p |-> $past(frame_end) && $past(addr_hit) && $past(word_in[sorc_pkg::RW_BIT]))
    else $error("read pulse without an addressed read word");
  rst_word_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
    st_q.rst_p |-> $past(word_in[sorc_pkg::SWRST_BIT]) && !current_out_en && !voltage_out_en)
    else $error("reset pulse without a reset write");
  self_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_13]
    !output_control_word[sorc_pkg::SWRST_BIT] && !output_control_word[sorc_pkg::SWCLR_BIT])
    else $error("command bit kept in control word");
  short_frame_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_17]
    (frame_end && st_q.count != sorc_pkg::BIT_COUNT_FULL) |=>
    $stable(st_q.ctrl) && !st_q.rd_p && !st_q.clr_p && !st_q.rst_p)
    else $error("partial frame acted upon");
  foreign_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
    (frame_end && !addr_hit) |=> !st_q.rd_p && !st_q.clr_p && !st_q.rst_p)
    else $error("foreign address raised a pulse");
  hw_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_15]
    !sw_mode |=> !st_q.rd_p && !st_q.clr_p && !st_q.rst_p && st_q.count == '0)
    else $error("serial path live in hardware mode");
  shift_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
    !(sw_mode && !link.sync_n_s && sclk_fall) |=> $stable(st_q.shift))
    else $error("shift register moved without a serial clock fall");
  count_max_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
    st_q.count <= sorc_pkg::BIT_COUNT_FULL + 5'h01)
    else $error("bit counter ran past its limit");

  // ---------------------------------------------------------------
  // range decode checks
  // ---------------------------------------------------------------
  range_i4_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    (!sense_resistor_select && range_code == 4'h0) |-> output_config == sorc_pkg::SORC_CFG_I4_20)
    else $error("external 4-20 mA code misdecoded");
  range_i24_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09]
    (!sense_resistor_select && range_code == 4'h2) |->
    output_config == sorc_pkg::SORC_CFG_I0_24 && current_out_en == output_enable_bit)
    else $error("external 0-24 mA code misdecoded");
  range_v5_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    (!sense_resistor_select && range_code == 4'h5) |->
    output_config == sorc_pkg::SORC_CFG_V0_5 && voltage_out_en == output_enable_bit)
    else $error("five volt code misdecoded");
  range_v40_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_10]
    (!sense_resistor_select && range_code == 4'he) |-> output_config == sorc_pkg::SORC_CFG_V0_40)
    else $error("forty volt code misdecoded");
  range_int_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
    (sense_resistor_select && range_code == 4'h0) |-> output_config == sorc_pkg::SORC_CFG_I4_20)
    else $error("internal 4-20 mA code misdecoded");
  range_int20_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
    (sense_resistor_select && range_code == 4'h1) |-> output_config == sorc_pkg::SORC_CFG_I0_20)
    else $error("internal 0-20 mA code misdecoded");
  range_int10_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_11]
    (sense_resistor_select && range_code == 4'h6) |->
    output_config == sorc_pkg::SORC_CFG_V0_10 && voltage_out_en == output_enable_bit)
    else $error("internal ten volt code misdecoded");
endmodule // sorc_serial_ctrl

// ---- rtl/sorc_pkg.sv ----
// Purpose: shared constants and types for the serial output range control block
// Assumes: 16-bit command words, msb first, sampled on serial clock falling edges
// Notes: range encodings follow the control word layout
package sorc_pkg;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 13;
  localparam int RW_BIT = 12;
  localparam int RSV_HI_BIT = 11;
  localparam int RANGE_HI = 10;
  localparam int RANGE_LO = 7;
  localparam int CLEAR_LEVEL_SELECT_BIT = 6;
  localparam int OUTPUT_ENABLE_BIT_BIT = 5;
  localparam int SWCLR_BIT = 4;
  localparam int RSEL_BIT = 3;
  localparam int SWRST_BIT = 2;
  localparam int RSV_LO1_BIT = 1;
  localparam int RSV_LO0_BIT = 0;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // ---------------------------------------------------------------
  // decoded output configuration
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SORC_CFG_NONE   = 4'h0,
    SORC_CFG_I4_20  = 4'h1,
    SORC_CFG_I0_20  = 4'h2,
    SORC_CFG_I0_24  = 4'h3,
    SORC_CFG_V0_5   = 4'h4,
    SORC_CFG_V0_10  = 4'h5,
    SORC_CFG_V0_6   = 4'h6,
    SORC_CFG_V0_12  = 4'h7,
    SORC_CFG_V0_40  = 4'h8,
    SORC_CFG_V0_44  = 4'h9,
    SORC_CFG_UNUSED = 4'hf
  } sorc_cfg_t;
endpackage : sorc_pkg

// ---- rtl/sorc_link_if.sv ----
// Purpose: carries sampled serial link levels from the synchroniser to the decoder
// Assumes: all signals in the clk domain
// Notes: levels only, already past two flip-flops
interface sorc_link_if;
  logic sclk_s;
  logic sdin_s;
  logic sync_n_s;
  modport sync_side (output sclk_s, output sdin_s, output sync_n_s);
  modport core_side (input sclk_s, input sdin_s, input sync_n_s);
endinterface : sorc_link_if

// ---- rtl/sorc_pin_sync.sv ----
// Purpose: two-flop synchroniser for the serial link pins
// Assumes: pins are asynchronous to clk
// Notes: first stage is read only by the second stage
module sorc_pin_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdin,
  input wire logic sync_n,
  sorc_link_if.sync_side link
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } sorc_sync_state_t;

  sorc_sync_state_t st_q;
  sorc_sync_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = {sclk, sdin, sync_n};
    st_d.s2 = st_q.s1;
  end

  // idle link: clock high, frame closed
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{s1: 3'h5, s2: 3'h5};
    end else begin
      st_q <= st_d;
    end
  end

  assign link.sclk_s = st_q.s2[2];
  assign link.sdin_s = st_q.s2[1];
  assign link.sync_n_s = st_q.s2[0];
endmodule // sorc_pin_sync

// ---- test/sorc_ctrl_model.sv ----
// Purpose: behavioural system controller driving the serial write link
// Assumes: link clock period 80 ns, clock idles high and stands still between frames
// Notes: data line shows the inverse of its last bit once a frame ends
module sorc_ctrl_model (
  output logic sclk,
  output logic sdin,
  output logic sync_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b1;
    sdin = 1'b0;
    sync_n = 1'b1;
  end
  // ----------------------------------------
  // one frame of n bits, msb first
  // ----------------------------------------
  task automatic send(input logic [15:0] w, input int n);
    sync_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdin = (i < 16) ? w[15 - i] : 1'b0;
      #40 sclk = 1'b0;
      #40 sclk = 1'b1;
    end
    #40 sync_n = 1'b1;
    sdin = ~sdin;
  endtask
endmodule // sorc_ctrl_model

// ---- test/sorc_serial_ctrl_tb.sv ----
// Purpose: self-checking bench of the serial output range control block
// Assumes: board straps at 5 unless a scenario moves them
// Notes: pulses are counted per clock so a stretched pulse shows up
module sorc_serial_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, sclk, sdin, sync_n, mode;
  logic [2:0] strap;
  logic [15:0] ocw;
  logic [3:0] rng, cfg;
  logic clrs, oen, rsel, clr_p, rst_p, rd_p, unused, cur_en, vol_en;
  int err_count = 0, cmp_count = 0, n_clr = 0, n_rst = 0, n_rd = 0;
  sorc_ctrl_model ctl (.sclk(sclk), .sdin(sdin), .sync_n(sync_n));
  sorc_serial_ctrl DUT (.clk(clk), .rst_n(rst_n), .sclk(sclk), .sdin(sdin), .sync_n(sync_n),
    .addr_strap_pin2(strap[2]), .addr_strap_pin1(strap[1]), .addr_strap_pin0(strap[0]),
    .control_mode_strap(mode), .output_control_word(ocw), .range_code(rng),
    .clear_level_select(clrs), .output_enable_bit(oen), .sense_resistor_select(rsel),
    .sw_clear_pulse(clr_p), .sw_reset_pulse(rst_p), .read_request_pulse(rd_p),
    .output_config(cfg), .config_unused(unused), .current_out_en(cur_en),
    .voltage_out_en(vol_en));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (clr_p === 1'b1) n_clr++;
    if (rst_p === 1'b1) n_rst++;
    if (rd_p === 1'b1) n_rd++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [15:0] wr(input logic [2:0] a, input logic rw, input logic rs,
      input logic [3:0] c, input logic cs, input logic oe, input logic sc, input logic sr);
    return {a, rw, 1'b0, c, cs, oe, sc, rs, sr, 2'b00};
  endfunction
  function automatic logic [3:0] exp_cfg(input logic rs, input logic [3:0] c);
    case ({rs, c})
      5'h00, 5'h10: return 4'h1;
      5'h01, 5'h11: return 4'h2;
      5'h02, 5'h12: return 4'h3;
      5'h05, 5'h15: return 4'h4;
      5'h06, 5'h16: return 4'h5;
      5'h09: return 4'h6;
      5'h0a: return 4'h7;
      5'h0e: return 4'h8;
      5'h0f: return 4'h9;
      default: return 4'hf;
    endcase
  endfunction
  // answer lands 3 clk after the frame closes; 8 leaves margin for jitter
  task automatic frame(input logic [15:0] w, input int n);
    ctl.send(w, n);
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic check_all(input logic [15:0] w);
    logic [3:0] c;
    c = exp_cfg(w[3], w[10:7]);
    check(ocw, w & 16'hffeb, "word");
    check({12'h0, rng}, {12'h0, w[10:7]}, "range");
    check({13'h0, clrs, oen, rsel}, {13'h0, w[6], w[5], w[3]}, "bits");
    check({12'h0, cfg}, {12'h0, c}, "config");
    check({13'h0, unused, cur_en, vol_en}, {13'h0, c == 4'hf, w[5] && c inside {[4'h1:4'h3]},
      w[5] && c inside {[4'h4:4'h9]}}, "enables");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_ranges();
    logic [15:0] w;
    // every legal code once; the controller never writes an unused combination
    for (int k = 0; k < 32; k++) begin
      if (exp_cfg(k[4], k[3:0]) != 4'hf) begin
        w = wr(3'h5, 1'b0, k[4], k[3:0], k[0], 1'b1, 1'b0, 1'b0);
        frame(w, 16);
        check_all(w);
      end
    end
  endtask
  task automatic t_addr();
    logic [15:0] w0;
    w0 = wr(3'h5, 1'b0, 1'b0, 4'h6, 1'b0, 1'b1, 1'b0, 1'b0);
    frame(w0, 16);
    for (int a = 0; a < 8; a++) begin
      if (a != 5) begin
        frame(wr(a[2:0], 1'b0, 1'b1, 4'h1, 1'b1, 1'b0, 1'b0, 1'b0), 16);
        check_all(w0);
      end
    end
    strap = 3'h2;
    repeat (4) @(posedge clk);
    #1;
    w0 = wr(3'h2, 1'b0, 1'b1, 4'h2, 1'b1, 1'b1, 1'b0, 1'b0);
    frame(w0, 16);
    check_all(w0);
    strap = 3'h5;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_other();
    logic [15:0] w;
    w = wr(3'h5, 1'b0, 1'b0, 4'h5, 1'b0, 1'b1, 1'b1, 1'b0);
    n_clr = 0;
    frame(w, 16);
    check_all(w);
    check(16'(n_clr), 16'h0001, "clear pulse");
    frame(wr(3'h5, 1'b0, 1'b0, 4'h9, 1'b1, 1'b1, 1'b0, 1'b0), 15);
    check_all(w);
    frame(wr(3'h5, 1'b0, 1'b0, 4'h9, 1'b1, 1'b1, 1'b0, 1'b0), 17);
    check_all(w);
    n_rd = 0;
    frame(wr(3'h5, 1'b1, 1'b0, 4'ha, 1'b0, 1'b0, 1'b0, 1'b0), 16);
    frame(wr(3'h4, 1'b1, 1'b0, 4'ha, 1'b0, 1'b0, 1'b0, 1'b0), 16);
    check(16'(n_rd), 16'h0001, "read pulse");
    check_all(w);
    mode = 1'b1;
    frame(wr(3'h5, 1'b0, 1'b0, 4'he, 1'b0, 1'b1, 1'b0, 1'b0), 16);
    check_all(w);
    mode = 1'b0;
    n_rst = 0;
    frame(wr(3'h5, 1'b0, 1'b0, 4'h2, 1'b1, 1'b1, 1'b0, 1'b1), 16);
    check_all(16'h0000);
    check(16'(n_rst), 16'h0001, "reset pulse");
  endtask
  task automatic summarize();
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    mode = 1'b0;
    strap = 3'h5;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 check_all(16'h0000);
    t_ranges();
    t_addr();
    t_other();
    summarize();
  end
  // about 30 frames of 1.4 us each; the limit leaves ample room
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule // sorc_serial_ctrl_tb
